/* File: verif/temp_monitor_register_map_bench.sv */
// self-checking bench of the register bank: reset values, access kinds, formatting
// assumes tmrm_regs with the default variant limit and the host model beside it
`timescale 1ns/10ps
`default_nettype none
module temp_monitor_register_map_bench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    tmrm_pkg::tmrm_bus_t  bus;
    tmrm_pkg::tmrm_conv_t conv = '0;
    logic [7:0] rd_data, got, nc;
    logic rd_valid, sup, sd, pin, rng, osh;
    logic [3:0] rate;
    logic [1:0] res;
    logic [47:0] lim_hi;
    logic [15:0] lim_lo;
    int num_errors = 0;
    int compares = 0;
    // reset table: read address and value after power-on
    localparam logic [7:0] RA [13] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h13,
        8'h14, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A};
    localparam logic [7:0] RV [13] = '{8'h00, 8'h08, 8'h55, 8'h00, 8'h55, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h55, 8'h1C};
    // write table: write address, data, read address, expected read-back
    localparam logic [7:0] WT [16][4] = '{'{8'h09, 8'hFF, 8'h03, 8'hE4},
        '{8'h0A, 8'hFF, 8'h04, 8'h0F}, '{8'h0B, 8'h12, 8'h05, 8'h12},
        '{8'h0C, 8'h34, 8'h06, 8'h34}, '{8'h0D, 8'h56, 8'h07, 8'h56},
        '{8'h0E, 8'h78, 8'h08, 8'h78}, '{8'h13, 8'hFF, 8'h13, 8'hF0},
        '{8'h14, 8'h5A, 8'h14, 8'h50}, '{8'h16, 8'hA7, 8'h16, 8'hA0},
        '{8'h17, 8'h3C, 8'h17, 8'h30}, '{8'h18, 8'hA5, 8'h18, 8'hA5},
        '{8'h19, 8'h3C, 8'h19, 8'h3C}, '{8'h1A, 8'hFF, 8'h1A, 8'h1F},
        '{8'h00, 8'hAA, 8'h00, 8'h2A}, '{8'h1B, 8'hAA, 8'h1B, 8'h00},
        '{8'h02, 8'h55, 8'h02, 8'h00}};
    // local low byte of 25.6875 degrees at each resolution code
    localparam logic [7:0] LO [4] = '{8'h80, 8'h80, 8'hA0, 8'hB0};

    always #20 clk = ~clk;

    tmrm_regs dut_u (.clk(clk), .reset_n(reset_n), .bus(bus), .conv(conv),
        .rd_data(rd_data), .rd_valid(rd_valid), .alert_suppress_bit(sup),
        .shutdown_bit(sd), .alert_pin_function_select(pin), .range_ext(rng),
        .conversion_rate_code(rate), .nonideality_code(nc),
        .local_resolution_sel(res), .limits_hi(lim_hi), .limits_lo(lim_lo), .one_shot(osh));

    tmrm_host_model host_u (.clk(clk), .bus(bus), .rd_data(rd_data), .rd_valid(rd_valid));

    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // read with pointer set first, then compare
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, 1'b1, got);
        chk(got, e);
    endtask
    // one finished conversion pulse
    task automatic cv(input logic [15:0] l, input logic [15:0] r, input logic [7:0] f);
        @(negedge clk);
        conv <= '{valid: 1'b1, local_t: l, remote_t: r, flags: f};
        @(negedge clk);
        conv.valid <= 1'b0;
    endtask

    task automatic test_done;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // hang guard, well beyond the few hundred cycles the sequence needs
    initial begin
        #2_000_000;
        num_errors++;
        test_done();
    end

    initial begin
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        // 25.6875 local, 50.4375 remote; a bare read must land on local high
        cv(16'h019B, 16'h0327, 8'h5A);
        host_u.rd(8'h00, 1'b0, got);
        chk(got, 8'h19);
        foreach (RA[i]) rc(RA[i], RV[i]);
        rc(8'h01, 8'h32);
        rc(8'h10, 8'h70);
        rc(8'h02, 8'h5A);
        // resolution takes hold at the next conversion
        for (int r = 0; r < 4; r++) begin
            host_u.wr(8'h1A, 8'(r), 1'b1);
            cv(16'h019B, 16'h0327, 8'h00);
            rc(8'h15, LO[r]);
        end
        // low byte read after high byte keeps the older conversion
        rc(8'h00, 8'h19);
        cv(16'h02A4, 16'h0327, 8'h00);
        rc(8'h15, 8'hB0);
        rc(8'h00, 8'h2A);
        foreach (WT[i]) begin
            host_u.wr(WT[i][0], WT[i][1], 1'b1);
            rc(WT[i][2], WT[i][3]);
        end
        chk({4'h0, sup, sd, pin, rng}, 8'h0F);
        chk({4'h0, rate}, 8'h0F);
        chk(nc, 8'hA5);
        chk({6'h00, res}, 8'h03);
        chk(lim_hi, 48'h1234_5678_3C00);
        chk(lim_lo, 48'h0000_0000_A3F5);
        host_u.wr(8'h0F, 8'h3C, 1'b1);
        chk({7'h00, osh}, 8'h01);
        rc(8'h0F, 8'h00);
        // extended range offsets high bytes by 64 from the next conversion
        host_u.wr(8'h09, 8'h04, 1'b1);
        rc(8'h00, 8'h2A);
        cv(16'h019B, 16'h0327, 8'h00);
        rc(8'h00, 8'h59);
        rc(8'h01, 8'h72);
        rc(8'h06, 8'h34);
        // two-byte read from 00: high byte, then its paired low byte
        host_u.wr(8'h00, 8'h00, 1'b0);
        host_u.put(1'b1, 1'b0, 1'b0, 8'h00);
        host_u.put(1'b0, 1'b0, 1'b1, 8'h00);
        host_u.put(1'b0, 1'b0, 1'b1, 8'h00);
        chk(rd_data, 8'h59);
        host_u.put(1'b0, 1'b0, 1'b0, 8'h00);
        chk(rd_data, 8'hB0);
        test_done();
    end
endmodule // temp_monitor_register_map_bench
`default_nettype wire

/* File: verif/tmrm_host_model.sv */
// host side of the bank: byte requests as a two-wire front end hands them over
// assumes the bank answers a read exactly one cycle after rd_req
`timescale 1ns/10ps
`default_nettype none
module tmrm_host_model (
    input  wire logic           clk,      // device clock
    output tmrm_pkg::tmrm_bus_t bus,      // byte requests to the bank
    input  wire logic [7:0]     rd_data,  // answered byte
    input  wire logic           rd_valid  // answer strobe
);
    initial bus = '0;
    // one request per falling edge; idle data flips so it never looks held
    task automatic put(input logic s, input logic w, input logic r, input logic [7:0] d);
        @(negedge clk);
        bus <= '{start: s, wr_valid: w, rd_req: r, data: (w ? d : ~bus.data)};
    endtask
    // pointer byte always goes first, data byte only when asked
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic dat);
        put(1'b1, 1'b0, 1'b0, 8'h00);
        put(1'b0, 1'b1, 1'b0, a);
        if (dat) put(1'b0, 1'b1, 1'b0, d);
        put(1'b0, 1'b0, 1'b0, 8'h00);
    endtask
    // pointer set by a write before the read, unless a bare read is wanted
    task automatic rd(input logic [7:0] a, input logic setp, output logic [7:0] d);
        if (setp) wr(a, 8'h00, 1'b0);
        put(1'b1, 1'b0, 1'b0, 8'h00);
        put(1'b0, 1'b0, 1'b1, 8'h00);
        put(1'b0, 1'b0, 1'b0, 8'h00);
        d = (rd_valid === 1'b1) ? rd_data : 8'hxx;
    endtask
endmodule // tmrm_host_model
`default_nettype wire

/* File: verilog/tmrm_defs.svh */
// constants of the temperature monitor register bank: addresses, reset values, fields
// assumes inclusion by the bank module only
`ifndef TMRM_DEFS_SVH
`define TMRM_DEFS_SVH

// read addresses
`define TMRM_RD_LT_HI      8'h00
`define TMRM_RD_RT_HI      8'h01
`define TMRM_RD_FLAGS      8'h02
`define TMRM_RD_CFG        8'h03
`define TMRM_RD_RATE       8'h04
`define TMRM_RD_LHL_HI     8'h05
`define TMRM_RD_LLL_HI     8'h06
`define TMRM_RD_RHL_HI     8'h07
`define TMRM_RD_RLL_HI     8'h08
`define TMRM_RD_RT_LO      8'h10
`define TMRM_RD_LT_LO      8'h15
// write addresses
`define TMRM_WR_CFG        8'h09
`define TMRM_WR_RATE       8'h0A
`define TMRM_WR_LHL_HI     8'h0B
`define TMRM_WR_LLL_HI     8'h0C
`define TMRM_WR_RHL_HI     8'h0D
`define TMRM_WR_RLL_HI     8'h0E
`define TMRM_WR_ONE_SHOT   8'h0F
// same address both ways
`define TMRM_RW_RHL_LO     8'h13
`define TMRM_RW_RLL_LO     8'h14
`define TMRM_RW_LHL_LO     8'h16
`define TMRM_RW_LLL_LO     8'h17
`define TMRM_RW_NC         8'h18
`define TMRM_RW_RCRIT      8'h19
`define TMRM_RW_RES        8'h1A

// reset values
`define TMRM_POR_PTR       8'h00
`define TMRM_POR_ZERO      8'h00
`define TMRM_POR_RATE      4'h8
`define TMRM_POR_HIGH_LIM  8'h55
`define TMRM_POR_HIGH_ALT  8'h6E
`define TMRM_POR_RES       2'h0

// field positions and fixed patterns
`define TMRM_CFG_SUPPRESS  7
`define TMRM_CFG_SHUTDOWN  6
`define TMRM_CFG_PINFUNC   5
`define TMRM_CFG_RANGE     2
`define TMRM_RES_FIXED     6'h07
`define TMRM_EXT_OFFSET    12'sh040
`define TMRM_STD_MAX       12'sh07F
`define TMRM_EXT_MAX       12'sh0FF

`endif

/* File: verilog/tmrm_pkg.sv */
// types shared by the temperature monitor register bank
// assumes tmrm_defs.svh holds the addresses, reset values and fields; this file holds types only
package tmrm_pkg;

    // byte-level requests from the two-wire front end
    typedef struct packed {
        logic       start;     // new transaction begins
        logic       wr_valid;  // host byte received
        logic       rd_req;    // host wants a byte
        logic [7:0] data;      // received byte
    } tmrm_bus_t;

    // one finished conversion from the measurement engine
    typedef struct packed {
        logic        valid;    // one-cycle pulse
        logic [15:0] local_t;  // signed, sixteenths of a degree
        logic [15:0] remote_t; // signed, sixteenths of a degree
        logic [7:0]  flags;    // monitor flags, busy in bit 7
    } tmrm_conv_t;

    // write-side transaction state
    typedef enum logic [1:0] {
        TMRM_W_PTR  = 2'b01,
        TMRM_W_DATA = 2'b10
    } tmrm_wst_t;

endpackage

/* File: verilog/tmrm_regs.sv */
// register bank of a local and remote temperature monitor behind a byte pointer
// assumes a two-wire front end that delivers bytes and a conversion engine upstream
//
// Behaviour
// - an 8-bit pointer picks the register for each following read or write
// - the first byte of every write transaction loads the pointer
// - pointer clears to zero at reset, so a bare read gives local high byte
// - local result read-only at 00 and 15, both reset to zero
// - remote result read-only at 01 and 10, both reset to zero
// - low bytes hold sixteenths in bits 7:4 for both ranges
// - local low byte truncated to the chosen resolution, unused bits zero
// - flags byte read-only at 02: busy, limit, fault and critical flags
// - config read at 03, written at 09, reset 00, unused bits zero
// - rate read at 04, written at 0A, reset 08, bits 7:4 zero
// - limit high bytes read 05..08, written 0B..0E, low limits reset 00
// - high and critical limits reset to a variant value, 55 or 6E
// - limit low bytes at 13,14,16,17 both ways, bits 7:4 held
// - write-only 0F triggers one conversion; read-only addresses refuse writes
// - non-ideality correction full 8-bit read-write at 18, reset 00
// - remote critical limit read-write at 19 with variant reset value
// - resolution at 1A resets 1C, bits 1:0 writable, 7:2 read 000111
// - extended range adds 64 to high bytes from the next conversion
// - low byte read after its high byte returns the same conversion
`include "tmrm_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module tmrm_regs #(
    parameter logic [7:0] HIGH_LIMIT_POR = `TMRM_POR_HIGH_LIM // variant power-on limit
) (
    input  wire logic                clk,           // 25 MHz device clock
    input  wire logic                reset_n,       // synchronous, active low
    input  wire tmrm_pkg::tmrm_bus_t bus,           // byte requests from front end
    input  wire tmrm_pkg::tmrm_conv_t conv,         // finished conversion
    output logic [7:0]               rd_data,       // byte answered to host
    output logic                     rd_valid,      // rd_data valid, one cycle
    output logic                     alert_suppress_bit,        // config bit 7
    output logic                     shutdown_bit,              // config bit 6
    output logic                     alert_pin_function_select, // config bit 5
    output logic                     range_ext,                 // config bit 2
    output logic [3:0]               conversion_rate_code,      // rate select
    output logic [7:0]               nonideality_code,          // correction factor
    output logic [1:0]               local_resolution_sel,      // local step select
    output logic [47:0]              limits_hi,     // lhl,lll,rhl,rll,rcrit,spare high bytes
    output logic [15:0]              limits_lo,     // lhl,lll,rhl,rll low nibbles
    output logic                     one_shot       // single conversion request pulse
);

    // refuse a power-on limit that no variant has
    if (HIGH_LIMIT_POR != `TMRM_POR_HIGH_LIM
        && HIGH_LIMIT_POR != `TMRM_POR_HIGH_ALT) begin : g_bad_por
        $error("HIGH_LIMIT_POR must be a documented variant value");
    end

    // state
    tmrm_pkg::tmrm_wst_t wst_q, wst_d;
    logic [7:0] ptr_q;
    logic       rd_idx_q;          // second byte of a read transaction
    logic [7:0] lt_hi_q, lt_lo_q, rt_hi_q, rt_lo_q, flags_q;
    logic [3:0] cfg_q;             // suppress, shutdown, pinfunc, range
    logic [3:0] rate_q;
    logic [7:0] lhl_hi_q, lll_hi_q, rhl_hi_q, rll_hi_q, rcrit_q, nc_q;
    logic [3:0] lhl_lo_q, lll_lo_q, rhl_lo_q, rll_lo_q;
    logic [1:0] res_q;
    logic [7:0] snap_lo_q;         // low byte captured with its high byte
    logic       snap_loc_q, snap_rem_q;
    logic [7:0] rd_data_q;
    logic       rd_valid_q, one_shot_q;

    // conversion formatting: clamp to range, offset in extended mode
    function automatic logic [15:0] tmrm_fmt(input logic [15:0] t, input logic ext);
        logic signed [11:0] ip;
        logic signed [11:0] v;
        logic [15:0]        r;
        ip = $signed(t[15:4]);
        // limitation: integer parts of 1984 or more wrap in the 12-bit sum; no diode reads that
        v  = ext ? ip + `TMRM_EXT_OFFSET : ip;
        if (v < 12'sh000) begin
            r = 16'h0000;
        end else if (v > (ext ? `TMRM_EXT_MAX : `TMRM_STD_MAX)) begin
            r = {v[7:0] & 8'h00 | (ext ? 8'hFF : 8'h7F), 8'h00};
        end else begin
            r = {v[7:0], t[3:0], 4'h0};
        end
        return r;
    endfunction

    // resolution mask for the local low byte
    function automatic logic [7:0] tmrm_res_mask(input logic [1:0] res);
        logic [7:0] m;
        unique case (res)
            2'h0: m = 8'h80;
            2'h1: m = 8'hC0;
            2'h2: m = 8'hE0;
            2'h3: m = 8'hF0;
        endcase
        return m;
    endfunction

    // transaction decode
    // writes never increment the pointer; repeated data bytes rewrite one register
    wire        ptr_load = bus.wr_valid && wst_q == tmrm_pkg::TMRM_W_PTR;
    wire        reg_wr   = bus.wr_valid && wst_q == tmrm_pkg::TMRM_W_DATA;
    wire [7:0]  wd       = bus.data;
    wire        we_cfg   = reg_wr && ptr_q == `TMRM_WR_CFG;
    wire        we_rate  = reg_wr && ptr_q == `TMRM_WR_RATE;
    wire        we_lhl   = reg_wr && ptr_q == `TMRM_WR_LHL_HI;
    wire        we_lll   = reg_wr && ptr_q == `TMRM_WR_LLL_HI;
    wire        we_rhl   = reg_wr && ptr_q == `TMRM_WR_RHL_HI;
    wire        we_rll   = reg_wr && ptr_q == `TMRM_WR_RLL_HI;
    wire        we_shot  = reg_wr && ptr_q == `TMRM_WR_ONE_SHOT;
    wire        we_rhl_l = reg_wr && ptr_q == `TMRM_RW_RHL_LO;
    wire        we_rll_l = reg_wr && ptr_q == `TMRM_RW_RLL_LO;
    wire        we_lhl_l = reg_wr && ptr_q == `TMRM_RW_LHL_LO;
    wire        we_lll_l = reg_wr && ptr_q == `TMRM_RW_LLL_LO;
    wire        we_nc    = reg_wr && ptr_q == `TMRM_RW_NC;
    wire        we_rcrit = reg_wr && ptr_q == `TMRM_RW_RCRIT;
    wire        we_res   = reg_wr && ptr_q == `TMRM_RW_RES;
    wire        we_any   = we_cfg | we_rate | we_lhl | we_lll | we_rhl | we_rll | we_shot
                         | we_rhl_l | we_rll_l | we_lhl_l | we_lll_l | we_nc | we_rcrit
                         | we_res;

    // a two-byte read from a result high byte continues with its low byte
    wire        rd_lt_hi = ptr_q == `TMRM_RD_LT_HI && !rd_idx_q;
    wire        rd_rt_hi = ptr_q == `TMRM_RD_RT_HI && !rd_idx_q;
    wire        rd_lt_lo = ptr_q == `TMRM_RD_LT_LO || (ptr_q == `TMRM_RD_LT_HI && rd_idx_q);
    wire        rd_rt_lo = ptr_q == `TMRM_RD_RT_LO || (ptr_q == `TMRM_RD_RT_HI && rd_idx_q);
    wire [7:0]  lt_lo_rd = snap_loc_q ? snap_lo_q : lt_lo_q;
    wire [7:0]  rt_lo_rd = snap_rem_q ? snap_lo_q : rt_lo_q;
    wire [7:0]  cfg_rd   = {cfg_q[3:1], 2'b00, cfg_q[0], 2'b00};

    // read selection; unmapped and write-only addresses answer zero
    wire [7:0]  rd_mux =
        rd_lt_hi                  ? lt_hi_q :
        rd_rt_hi                  ? rt_hi_q :
        rd_lt_lo                  ? lt_lo_rd :
        rd_rt_lo                  ? rt_lo_rd :
        ptr_q == `TMRM_RD_FLAGS   ? flags_q :
        ptr_q == `TMRM_RD_CFG     ? cfg_rd :
        ptr_q == `TMRM_RD_RATE    ? {4'h0, rate_q} :
        ptr_q == `TMRM_RD_LHL_HI  ? lhl_hi_q :
        ptr_q == `TMRM_RD_LLL_HI  ? lll_hi_q :
        ptr_q == `TMRM_RD_RHL_HI  ? rhl_hi_q :
        ptr_q == `TMRM_RD_RLL_HI  ? rll_hi_q :
        ptr_q == `TMRM_RW_RHL_LO  ? {rhl_lo_q, 4'h0} :
        ptr_q == `TMRM_RW_RLL_LO  ? {rll_lo_q, 4'h0} :
        ptr_q == `TMRM_RW_LHL_LO  ? {lhl_lo_q, 4'h0} :
        ptr_q == `TMRM_RW_LLL_LO  ? {lll_lo_q, 4'h0} :
        ptr_q == `TMRM_RW_NC      ? nc_q :
        ptr_q == `TMRM_RW_RCRIT   ? rcrit_q :
        ptr_q == `TMRM_RW_RES     ? {`TMRM_RES_FIXED, res_q} :
                                    8'h00;

    // formatted conversion results, range latched at the conversion itself
    wire [15:0] lt_fmt = tmrm_fmt(conv.local_t, cfg_q[0]);
    wire [15:0] rt_fmt = tmrm_fmt(conv.remote_t, cfg_q[0]);
    wire [7:0]  lt_lo_m = lt_fmt[7:0] & tmrm_res_mask(res_q);

    // write-side state: a new transaction always expects the pointer first
    // a read transaction leaves the write state waiting for a pointer byte
    always_comb begin
        wst_d = wst_q;
        if (bus.start) begin
            wst_d = tmrm_pkg::TMRM_W_PTR;
        end else if (ptr_load) begin
            wst_d = tmrm_pkg::TMRM_W_DATA;
        end
    end

    // pointer, transaction index and the read answer
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wst_q      <= tmrm_pkg::TMRM_W_PTR;
            ptr_q      <= `TMRM_POR_PTR;
            rd_idx_q   <= 1'b0;
            rd_data_q  <= `TMRM_POR_ZERO;
            rd_valid_q <= 1'b0;
        end else begin
            wst_q      <= wst_d;
            if (ptr_load) begin
                ptr_q <= wd;
            end
            if (bus.start) begin
                rd_idx_q <= 1'b0;
            end else if (bus.rd_req) begin
                rd_idx_q <= 1'b1;
            end
            rd_valid_q <= bus.rd_req;
            if (bus.rd_req) begin
                rd_data_q <= rd_mux;
            end
        end
    end

    // same-conversion guarantee: snapshot low byte at the high-byte read, drop on other read
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            snap_lo_q  <= `TMRM_POR_ZERO;
            snap_loc_q <= 1'b0;
            snap_rem_q <= 1'b0;
        end else if (bus.rd_req) begin
            snap_lo_q  <= rd_lt_hi ? lt_lo_q : rt_lo_q;
            snap_loc_q <= rd_lt_hi;
            snap_rem_q <= rd_rt_hi;
        end
    end

    // results and flags from the conversion engine; the host cannot write them
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lt_hi_q <= `TMRM_POR_ZERO;
            lt_lo_q <= `TMRM_POR_ZERO;
            rt_hi_q <= `TMRM_POR_ZERO;
            rt_lo_q <= `TMRM_POR_ZERO;
            flags_q <= `TMRM_POR_ZERO;
        end else if (conv.valid) begin
            lt_hi_q <= lt_fmt[15:8];
            lt_lo_q <= lt_lo_m;
            rt_hi_q <= rt_fmt[15:8];
            rt_lo_q <= rt_fmt[7:0];
            flags_q <= conv.flags;
        end
    end

    // control registers; a write to any other address leaves them alone
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfg_q  <= 4'h0;
            rate_q <= `TMRM_POR_RATE;
            nc_q   <= `TMRM_POR_ZERO;
            res_q  <= `TMRM_POR_RES;
        end else begin
            if (we_cfg) begin
                cfg_q <= {wd[`TMRM_CFG_SUPPRESS], wd[`TMRM_CFG_SHUTDOWN],
                          wd[`TMRM_CFG_PINFUNC], wd[`TMRM_CFG_RANGE]};
            end
            if (we_rate) begin
                rate_q <= wd[3:0];
            end
            if (we_nc) begin
                nc_q <= wd;
            end
            if (we_res) begin
                res_q <= wd[1:0];
            end
        end
    end

    // limit registers: high limits and the critical limit reset to the variant value
    // the low bytes keep only bits 7:4; the lower nibble reads zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lhl_hi_q <= HIGH_LIMIT_POR;
            rhl_hi_q <= HIGH_LIMIT_POR;
            rcrit_q  <= HIGH_LIMIT_POR;
            lll_hi_q <= `TMRM_POR_ZERO;
            rll_hi_q <= `TMRM_POR_ZERO;
            lhl_lo_q <= 4'h0;
            lll_lo_q <= 4'h0;
            rhl_lo_q <= 4'h0;
            rll_lo_q <= 4'h0;
        end else begin
            if (we_lhl)   lhl_hi_q <= wd;
            if (we_lll)   lll_hi_q <= wd;
            if (we_rhl)   rhl_hi_q <= wd;
            if (we_rll)   rll_hi_q <= wd;
            if (we_rcrit) rcrit_q  <= wd;
            if (we_lhl_l) lhl_lo_q <= wd[7:4];
            if (we_lll_l) lll_lo_q <= wd[7:4];
            if (we_rhl_l) rhl_lo_q <= wd[7:4];
            if (we_rll_l) rll_lo_q <= wd[7:4];
        end
    end

    // one-shot: any data byte written at its address requests one conversion
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            one_shot_q <= 1'b0;
        end else begin
            one_shot_q <= we_shot;
        end
    end

    // outputs straight from flip-flops
    // spare low byte of limits_hi reads zero and pads the vector to six bytes
    assign rd_data                   = rd_data_q;
    assign rd_valid                  = rd_valid_q;
    assign alert_suppress_bit        = cfg_q[3];
    assign shutdown_bit              = cfg_q[2];
    assign alert_pin_function_select = cfg_q[1];
    assign range_ext                 = cfg_q[0];
    assign conversion_rate_code      = rate_q;
    assign nonideality_code          = nc_q;
    assign local_resolution_sel      = res_q;
    assign limits_hi                 = {lhl_hi_q, lll_hi_q, rhl_hi_q, rll_hi_q, rcrit_q, 8'h00};
    assign limits_lo                 = {lhl_lo_q, lll_lo_q, rhl_lo_q, rll_lo_q};
    assign one_shot                  = one_shot_q;

    // checks
    // they watch the bank's registers and outputs; bus and conversion inputs open them and give some expected values
    property p_ptr_load;
        @(posedge clk) disable iff (!reset_n)
        ptr_load && !bus.start |=> ptr_q == $past(bus.data);
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

    property p_rd_answer;
        @(posedge clk) disable iff (!reset_n)
        bus.rd_req |=> rd_valid ##1 (!rd_valid || $past(bus.rd_req));
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");

    property p_lt_read;
        @(posedge clk) disable iff (!reset_n)
        bus.rd_req && ptr_q == `TMRM_RD_LT_HI && !rd_idx_q |=> rd_data == $past(lt_hi_q);
    endproperty
    a_lt_read: assert property (p_lt_read) else $error("local high byte wrong");

    property p_rate_wr;
        @(posedge clk) disable iff (!reset_n)
        we_rate |=> conversion_rate_code == $past(bus.data[3:0]);
    endproperty
    a_rate_wr: assert property (p_rate_wr) else $error("rate not stored");

    property p_ro_write;
        @(posedge clk) disable iff (!reset_n)
        reg_wr && !we_any |=> $stable(cfg_q) && $stable(rate_q) && $stable(nc_q)
                              && $stable(lhl_hi_q) && $stable(res_q);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("refused write took");

    property p_res_fixed;
        @(posedge clk) disable iff (!reset_n)
        bus.rd_req && ptr_q == `TMRM_RW_RES |=> rd_data[7:2] == 6'b000111;
    endproperty
    a_res_fixed: assert property (p_res_fixed) else $error("resolution pattern");

    property p_one_shot;
        @(posedge clk) disable iff (!reset_n)
        we_shot ##1 !we_shot |-> one_shot ##1 !one_shot;
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("one-shot pulse");

    property p_snap;
        @(posedge clk) disable iff (!reset_n)
        bus.rd_req && rd_lt_lo && snap_loc_q |=> rd_data == $past(snap_lo_q);
    endproperty
    a_snap: assert property (p_snap) else $error("low byte not paired");

    property p_range;
        @(posedge clk) disable iff (!reset_n)
        conv.valid && range_ext && conv.local_t[15:10] == 6'h00
        |=> lt_hi_q == {2'b01, $past(conv.local_t[9:4])};
    endproperty
    a_range: assert property (p_range) else $error("extended offset");

    property p_trunc;
        @(posedge clk) disable iff (!reset_n)
        conv.valid && res_q == 2'h0 |=> lt_lo_q[6:0] == 7'h00;
    endproperty
    a_trunc: assert property (p_trunc) else $error("local low not truncated");

    c_two_byte: cover property (@(posedge clk) disable iff (!reset_n)
        bus.rd_req && rd_lt_hi ##1 bus.rd_req && rd_lt_lo);
    c_cfg_wr:   cover property (@(posedge clk) disable iff (!reset_n) we_cfg);
    c_shot:     cover property (@(posedge clk) disable iff (!reset_n) one_shot);
    c_ro_write: cover property (@(posedge clk) disable iff (!reset_n) reg_wr && !we_any);
    c_ext_conv: cover property (@(posedge clk) disable iff (!reset_n) conv.valid && range_ext);

endmodule // tmrm_regs

`default_nettype wire
